// ### hdl/rca_calendar_regs.sv
// Calendar, alarm, control and status registers of the real-time clock.
// Functional notes
// - Year and alarm year are two BCD digits: tens in 7:4, units in 3:0.
// - Month is BCD: one-bit tens in bit 4, units in 3:0, reset one.
// - Weekday is bits 2:0, range 0 to 6; upper five bits read zero.
// - Alarm hour bit 7 is PM only in twelve-hour mode; tens 5:4 up to 2.
// - Alarm day: tens 5:4 up to 3, units 3:0 resetting to one.
// - Alarm month: tens bit 4, units 3:0 resetting to one, bits 7:5 zero.
// - Control bit 7 selects live counters (0) or shadow copies (1) for reads.
// - Writing control bit 6 from zero to one snapshots live time into shadows.
// - Writing one to control bit 5 loads the sub-second counter from compensation.
// - Control bit 3 picks 24-hour (0) or 12-hour (1) format without disturbing count.
// - Control bit 2 enables automatic drift compensation.
// - Writing one to control bit 1 rounds to nearest minute; bit self-clears.
// - Control bit 0 freezes (0) or runs (1) the clock; resets frozen.
// - Status bit 7 is set by reset, cleared by writing one.
// - Status bit 6 marks alarm; alarm output stays low until one is written.
// - Periodic interrupt is a single fixed-length active-low pulse.
// - Status bits 5 to 2 flag elapsed day, hour, minute and second.
// - Status bit 1 shows real running state, lagging the freeze control.
// - Interrupt-control bit 4 holds periodic events during sleep, delivering one pulse afterwards.
// - Interrupt-control bit 3 enables one interrupt on alarm match.
// - Interrupt-control bit 2 enables periodic interrupt; disabled after reset.
// - Interrupt-control bits 1:0 choose second, minute, hour or day period.
`timescale 1ns/10ps
`default_nettype none
module rca_calendar_regs #(
	parameter int TICKS_PER_SECOND = 32768
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_32k,
	input  wire logic        i_sleep,
	input  wire logic [15:0] i_comp_value,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	output logic             o_alarm_irq_n,
	output logic             o_timer_irq_n
);
	localparam logic [rca_pkg::SUBSECOND_W-1:0] TICK_LAST = rca_pkg::SUBSECOND_W'(TICKS_PER_SECOND - 1);

	rca_pkg::rca_state_t q;
	rca_pkg::rca_state_t next_q;
	logic                edge32;

	function automatic logic [7:0] to_bcd(input logic [6:0] v);
		logic [6:0] tens;
		logic [6:0] units;
		tens = v / 7'd10;
		units = v % 7'd10;
		return {tens[3:0], units[3:0]};
	endfunction : to_bcd

	function automatic logic [6:0] from_bcd(input logic [7:0] v);
		return 7'(v[7:4] * 4'd10) + {3'h0, v[3:0]};
	endfunction : from_bcd

	// Out-of-range digits are clamped, never stored as non-BCD codes.
	function automatic logic [7:0] lim(input logic [7:0] v, input logic [3:0] tmax);
		logic [3:0] tens;
		logic [3:0] units;
		tens = (v[7:4] > tmax) ? tmax : v[7:4];
		units = (v[3:0] > 4'h9) ? 4'h9 : v[3:0];
		return {tens, units};
	endfunction : lim

	function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
		logic [4:0] d;
		d = 5'h1F;
		if (m == 4'h2) begin
			d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
		end else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
			d = 5'h1E;
		end
		return d;
	endfunction : month_days

	// Hours are counted in 24-hour binary so a format switch never disturbs counting.
	function automatic logic [7:0] hour_image(input logic [4:0] h, input logic twelve);
		logic [4:0] h12;
		logic [7:0] b;
		h12 = (h >= 5'h0C) ? 5'(h - 5'h0C) : h;
		if (h12 == 5'h00) begin
			h12 = 5'h0C;
		end
		b = to_bcd({2'h0, h12});
		return twelve ? {(h >= 5'h0C), 1'b0, b[5:0]} : to_bcd({2'h0, h});
	endfunction : hour_image

	function automatic logic [4:0] hour_from(input logic [7:0] w, input logic twelve);
		logic [6:0] h;
		h = from_bcd(lim({2'h0, w[5:0]}, 4'h2));
		if (twelve) begin
			h = (h == 7'h0C || h > 7'h0C) ? 7'h00 : h;
			h = w[7] ? 7'(h + 7'h0C) : h;
		end
		return (h > 7'h17) ? 5'h17 : h[4:0];
	endfunction : hour_from

	always_comb begin
		logic                 sec_t;
		logic                 min_t;
		logic                 hour_t;
		logic                 day_t;
		logic                 rounding;
		logic                 per_ev;
		logic                 twelve;
		logic                 wr_ctrl_snap;
		logic                 match;
		logic [7:0]           alm_hour;
		logic [2:0]           aidx;
		rca_pkg::rca_time_t   rt;
		sec_t = 1'b0;
		min_t = 1'b0;
		hour_t = 1'b0;
		day_t = 1'b0;
		rounding = 1'b0;
		per_ev = 1'b0;
		match = 1'b0;
		twelve = q.ctrl[rca_pkg::CTRL_TWELVE_HOUR_FORMAT];
		wr_ctrl_snap = 1'b0;
		aidx = 3'(i_reg_addr - rca_pkg::OFF_ALM_SECOND);
		alm_hour = twelve ? q.alarm[2] : {1'b0, q.alarm[2][6:0]};
		rt = q.ctrl[rca_pkg::CTRL_READ_SOURCE_SELECT] ? q.shadow : q.live;
		next_q = q;
		edge32 = q.clk32_sync[1] & ~q.clk32_prev;
		next_q.clk32_sync = {q.clk32_sync[0], i_clk_32k};
		next_q.clk32_prev = q.clk32_sync[1];
		next_q.sleep_sync = {q.sleep_sync[0], i_sleep};
		next_q.tick_d = 1'b0;

		// The freeze control only takes effect on an oscillator edge, so the run state lags it.
		if (edge32) begin
			next_q.run = q.ctrl[rca_pkg::CTRL_RUN_ENABLE];
			if (q.run) begin
				if (q.subsecond == TICK_LAST) begin
					next_q.subsecond = '0;
					sec_t = 1'b1;
				end else begin
					next_q.subsecond = q.subsecond + 1'b1;
				end
			end
			if (q.ctrl[rca_pkg::CTRL_ROUND_TO_MINUTE]) begin
				rounding = 1'b1;
				next_q.ctrl[rca_pkg::CTRL_ROUND_TO_MINUTE] = 1'b0;
				next_q.live.second = 6'h00;
				min_t = (q.live.second >= 6'h1E);
			end
		end
		if (sec_t && !rounding) begin
			if (q.live.second == 6'h3B) begin
				next_q.live.second = 6'h00;
				min_t = 1'b1;
			end else begin
				next_q.live.second = q.live.second + 1'b1;
			end
		end
		if (min_t) begin
			if (q.live.minute == 6'h3B) begin
				next_q.live.minute = 6'h00;
				hour_t = 1'b1;
			end else begin
				next_q.live.minute = q.live.minute + 1'b1;
			end
		end
		if (hour_t) begin
			if (q.ctrl[rca_pkg::CTRL_AUTO_COMP]) begin
				next_q.subsecond = rca_pkg::SUBSECOND_W'(next_q.subsecond + i_comp_value[14:0]);
			end
			if (q.live.hour == 5'h17) begin
				next_q.live.hour = 5'h00;
				day_t = 1'b1;
			end else begin
				next_q.live.hour = q.live.hour + 1'b1;
			end
		end
		if (day_t) begin
			next_q.live.weekday = (q.live.weekday == 3'h6) ? 3'h0 : q.live.weekday + 1'b1;
			if (q.live.day >= month_days(q.live.month, q.live.year)) begin
				next_q.live.day = 5'h01;
				if (q.live.month == 4'hC) begin
					next_q.live.month = 4'h1;
					next_q.live.year = (q.live.year == 7'h63) ? 7'h00 : q.live.year + 1'b1;
				end else begin
					next_q.live.month = q.live.month + 1'b1;
				end
			end else begin
				next_q.live.day = q.live.day + 1'b1;
			end
		end
		next_q.tick_d = sec_t | min_t;

		if (i_reg_wr) begin
			case (i_reg_addr)
				rca_pkg::OFF_SECOND: next_q.live.second = 6'(from_bcd(lim({1'b0, i_reg_wdata[6:0]}, 4'h5)));
				rca_pkg::OFF_MINUTE: next_q.live.minute = 6'(from_bcd(lim({1'b0, i_reg_wdata[6:0]}, 4'h5)));
				rca_pkg::OFF_HOUR: next_q.live.hour = hour_from(i_reg_wdata, twelve);
				rca_pkg::OFF_DAY: next_q.live.day = 5'(from_bcd(lim({2'h0, i_reg_wdata[5:0]}, 4'h3)));
				rca_pkg::OFF_MONTH: next_q.live.month = 4'(from_bcd(lim({3'h0, i_reg_wdata[4:0]}, 4'h1)));
				rca_pkg::OFF_YEAR: next_q.live.year = from_bcd(lim(i_reg_wdata, 4'h9));
				rca_pkg::OFF_WEEKDAY: next_q.live.weekday = (i_reg_wdata[2:0] > 3'h6) ? 3'h6 : i_reg_wdata[2:0];
				rca_pkg::OFF_ALM_SECOND, rca_pkg::OFF_ALM_MINUTE: begin
					next_q.alarm[aidx] = lim({1'b0, i_reg_wdata[6:0]}, 4'h5);
				end
				rca_pkg::OFF_ALM_HOUR: begin
					next_q.alarm[aidx] = {i_reg_wdata[7] & twelve, 1'b0, 6'(lim({2'h0, i_reg_wdata[5:0]}, 4'h2))};
				end
				rca_pkg::OFF_ALM_DAY: next_q.alarm[aidx] = lim({2'h0, i_reg_wdata[5:0]}, 4'h3);
				rca_pkg::OFF_ALM_MONTH: next_q.alarm[aidx] = lim({3'h0, i_reg_wdata[4:0]}, 4'h1);
				rca_pkg::OFF_ALM_YEAR: next_q.alarm[aidx] = lim(i_reg_wdata, 4'h9);
				rca_pkg::OFF_CTRL: begin
					next_q.ctrl = {i_reg_wdata[7:2], q.ctrl[1] | i_reg_wdata[1], i_reg_wdata[0]};
					wr_ctrl_snap = i_reg_wdata[6] & ~q.ctrl[rca_pkg::CTRL_SNAPSHOT_REQUEST];
					if (i_reg_wdata[rca_pkg::CTRL_LOAD_SUBSECOND]) begin
						next_q.subsecond = i_comp_value[14:0];
					end
				end
				rca_pkg::OFF_STATUS: begin
					next_q.power_up = q.power_up & ~i_reg_wdata[rca_pkg::STAT_POWER_UP];
					next_q.alarm_flag = q.alarm_flag & ~i_reg_wdata[rca_pkg::STAT_ALARM];
				end
				rca_pkg::OFF_INTC: next_q.intc = i_reg_wdata[4:0];
				default: begin
				end
			endcase
		end
		if (wr_ctrl_snap) begin
			next_q.shadow = q.live;
		end

		// Elapsed flags clear on a status read; a new event in the same cycle still wins.
		if (i_reg_rd && i_reg_addr == rca_pkg::OFF_STATUS) begin
			next_q.events = 4'h0;
		end
		next_q.events = next_q.events | {day_t, hour_t, min_t, sec_t};

		match = (to_bcd({1'b0, q.live.second}) == q.alarm[0]) && (to_bcd({1'b0, q.live.minute}) == q.alarm[1])
			&& (hour_image(q.live.hour, twelve) == alm_hour) && (to_bcd({2'h0, q.live.day}) == q.alarm[3])
			&& (to_bcd({3'h0, q.live.month}) == q.alarm[4]) && (to_bcd(q.live.year) == q.alarm[5]);
		if (q.tick_d && q.intc[rca_pkg::INTC_ALARM_IRQ_ENABLE] && match) begin
			next_q.alarm_flag = 1'b1;
		end
		next_q.alarm_irq_n = ~next_q.alarm_flag;

		case (q.intc[1:0])
			rca_pkg::EVERY_SECOND: per_ev = sec_t;
			rca_pkg::EVERY_MINUTE: per_ev = min_t;
			rca_pkg::EVERY_HOUR: per_ev = hour_t;
			rca_pkg::EVERY_DAY: per_ev = day_t;
			default: per_ev = 1'b0;
		endcase
		if (q.pulse_cnt != '0) begin
			next_q.pulse_cnt = q.pulse_cnt - 1'b1;
		end else if (q.per_pend && !(q.intc[rca_pkg::INTC_SLEEP_PERIODIC_HOLD] && q.sleep_sync[1])) begin
			next_q.per_pend = 1'b0;
			next_q.pulse_cnt = rca_pkg::PULSE_W'(rca_pkg::TIMER_PULSE_CYC);
		end
		if (q.intc[rca_pkg::INTC_PERIODIC_IRQ_ENABLE] && per_ev) begin
			next_q.per_pend = 1'b1;
		end
		next_q.timer_irq_n = (next_q.pulse_cnt == '0);

		if (i_reg_rd) begin
			case (i_reg_addr)
				rca_pkg::OFF_SECOND: next_q.rdata = to_bcd({1'b0, rt.second});
				rca_pkg::OFF_MINUTE: next_q.rdata = to_bcd({1'b0, rt.minute});
				rca_pkg::OFF_HOUR: next_q.rdata = hour_image(rt.hour, twelve);
				rca_pkg::OFF_DAY: next_q.rdata = to_bcd({2'h0, rt.day});
				rca_pkg::OFF_MONTH: next_q.rdata = to_bcd({3'h0, rt.month});
				rca_pkg::OFF_YEAR: next_q.rdata = to_bcd(rt.year);
				rca_pkg::OFF_WEEKDAY: next_q.rdata = {5'h00, rt.weekday};
				rca_pkg::OFF_ALM_HOUR: next_q.rdata = alm_hour;
				rca_pkg::OFF_ALM_SECOND, rca_pkg::OFF_ALM_MINUTE, rca_pkg::OFF_ALM_DAY,
				rca_pkg::OFF_ALM_MONTH, rca_pkg::OFF_ALM_YEAR: next_q.rdata = q.alarm[aidx];
				rca_pkg::OFF_CTRL: next_q.rdata = q.ctrl;
				rca_pkg::OFF_STATUS: next_q.rdata = {q.power_up, q.alarm_flag, q.events, q.run, 1'b0};
				rca_pkg::OFF_INTC: next_q.rdata = {3'h0, q.intc};
				default: next_q.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
			q.live.day <= rca_pkg::RST_DAY;
			q.live.month <= rca_pkg::RST_MONTH;
			q.shadow.day <= rca_pkg::RST_DAY;
			q.shadow.month <= rca_pkg::RST_MONTH;
			q.alarm[3] <= rca_pkg::RST_ALM_DAY;
			q.alarm[4] <= rca_pkg::RST_ALM_MONTH;
			q.ctrl <= rca_pkg::RST_CTRL;
			q.power_up <= 1'b1;
			q.alarm_irq_n <= 1'b1;
			q.timer_irq_n <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign o_reg_rdata = q.rdata;
	assign o_alarm_irq_n = q.alarm_irq_n;
	assign o_timer_irq_n = q.timer_irq_n;

	// Checks of the guarded behaviour; helper logic counts the timer pulse length.
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	logic [rca_pkg::PULSE_W-1:0] low_cnt;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= o_timer_irq_n ? '0 : rca_pkg::PULSE_W'(low_cnt + 1'b1);
		end
	end

	a_year_digits: assert property (q.live.year < 7'h64 && q.alarm[5][3:0] < 4'hA)
		else $error("Year digit out of range.");
	a_month_range: assert property (q.live.month >= 4'h1 && q.live.month <= 4'hC)
		else $error("Month counter out of range.");
	a_weekday_read: assert property (i_reg_rd && i_reg_addr == rca_pkg::OFF_WEEKDAY |=> o_reg_rdata[7:3] == 5'h00 && o_reg_rdata[2:0] <= 3'h6)
		else $error("Weekday read has bad bits.");
	a_alm_hour_pm: assert property (i_reg_rd && i_reg_addr == rca_pkg::OFF_ALM_HOUR && !twelve_q() |=> !o_reg_rdata[7])
		else $error("Alarm PM flag visible in 24-hour mode.");
	a_snapshot_copy: assert property (i_reg_wr && i_reg_addr == rca_pkg::OFF_CTRL && i_reg_wdata[6] && !q.ctrl[6] |=> q.shadow == $past(q.live))
		else $error("Snapshot did not copy live time.");
	a_round_result: assert property ($fell(q.ctrl[rca_pkg::CTRL_ROUND_TO_MINUTE]) |-> q.live.second == 6'h00)
		else $error("Rounding left seconds nonzero.");
	a_frozen_hold: assert property (!q.run && !$past(q.run) && !$past(q.ctrl[1]) && !$past(i_reg_wr) |-> $stable(q.live))
		else $error("Time moved while frozen.");
	a_power_up_clear: assert property (i_reg_wr && i_reg_addr == rca_pkg::OFF_STATUS && i_reg_wdata[7] |=> !q.power_up)
		else $error("Power-up flag not cleared.");
	a_alarm_level: assert property (q.alarm_flag |-> !o_alarm_irq_n)
		else $error("Alarm output not held low.");
	a_timer_pulse_len: assert property ($rose(o_timer_irq_n) |-> low_cnt == rca_pkg::PULSE_W'(rca_pkg::TIMER_PULSE_CYC))
		else $error("Timer pulse length wrong.");
	a_run_lag: assert property ($changed(q.run) |-> $past(edge32))
		else $error("Run state changed off an oscillator edge.");
	a_sleep_hold: assert property (q.sleep_sync[1] && q.intc[4] && q.pulse_cnt == '0 && o_timer_irq_n |=> o_timer_irq_n)
		else $error("Periodic pulse issued during sleep.");

	c_alarm_fires: cover property ($fell(o_alarm_irq_n));
	c_timer_pulse: cover property ($fell(o_timer_irq_n));
	c_snapshot: cover property (i_reg_wr && i_reg_addr == rca_pkg::OFF_CTRL && i_reg_wdata[6] && !q.ctrl[6]);
	c_round_done: cover property ($fell(q.ctrl[rca_pkg::CTRL_ROUND_TO_MINUTE]));

	function automatic logic twelve_q();
		return q.ctrl[rca_pkg::CTRL_TWELVE_HOUR_FORMAT];
	endfunction : twelve_q
endmodule : rca_calendar_regs
`default_nettype wire

// ### include/rca_pkg.sv
// Package with the register map, field layout, reset values and state types of the calendar block.
package rca_pkg;
	localparam logic [7:0] OFF_SECOND       = 8'h00;
	localparam logic [7:0] OFF_MINUTE       = 8'h01;
	localparam logic [7:0] OFF_HOUR         = 8'h02;
	localparam logic [7:0] OFF_DAY          = 8'h03;
	localparam logic [7:0] OFF_MONTH        = 8'h04;
	localparam logic [7:0] OFF_YEAR         = 8'h05;
	localparam logic [7:0] OFF_WEEKDAY      = 8'h06;
	localparam logic [7:0] OFF_ALM_SECOND   = 8'h08;
	localparam logic [7:0] OFF_ALM_MINUTE   = 8'h09;
	localparam logic [7:0] OFF_ALM_HOUR     = 8'h0A;
	localparam logic [7:0] OFF_ALM_DAY      = 8'h0B;
	localparam logic [7:0] OFF_ALM_MONTH    = 8'h0C;
	localparam logic [7:0] OFF_ALM_YEAR     = 8'h0D;
	localparam logic [7:0] OFF_CTRL         = 8'h10;
	localparam logic [7:0] OFF_STATUS       = 8'h11;
	localparam logic [7:0] OFF_INTC         = 8'h12;
	localparam int CTRL_READ_SOURCE_SELECT  = 7;
	localparam int CTRL_SNAPSHOT_REQUEST    = 6;
	localparam int CTRL_LOAD_SUBSECOND      = 5;
	localparam int CTRL_TWELVE_HOUR_FORMAT  = 3;
	localparam int CTRL_AUTO_COMP           = 2;
	localparam int CTRL_ROUND_TO_MINUTE     = 1;
	localparam int CTRL_RUN_ENABLE          = 0;
	localparam int STAT_POWER_UP            = 7;
	localparam int STAT_ALARM               = 6;
	localparam int INTC_SLEEP_PERIODIC_HOLD = 4;
	localparam int INTC_ALARM_IRQ_ENABLE    = 3;
	localparam int INTC_PERIODIC_IRQ_ENABLE = 2;
	localparam logic [1:0] EVERY_SECOND     = 2'h0;
	localparam logic [1:0] EVERY_MINUTE     = 2'h1;
	localparam logic [1:0] EVERY_HOUR       = 2'h2;
	localparam logic [1:0] EVERY_DAY        = 2'h3;
	localparam logic [7:0] RST_CTRL         = 8'h00;
	localparam logic [4:0] RST_DAY          = 5'h01;
	localparam logic [3:0] RST_MONTH        = 4'h1;
	localparam logic [7:0] RST_ALM_DAY      = 8'h01;
	localparam logic [7:0] RST_ALM_MONTH    = 8'h01;
	localparam int SYS_CLK_PERIOD_NS        = 10;
	localparam int TIMER_PULSE_NS           = 15000;
	localparam int TIMER_PULSE_CYC          = TIMER_PULSE_NS / SYS_CLK_PERIOD_NS;
	localparam int SUBSECOND_W              = 15;
	localparam int PULSE_W                  = 11;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
		logic [2:0] weekday;
	} rca_time_t;

	typedef struct packed {
		logic [1:0]             clk32_sync;
		logic                   clk32_prev;
		logic [1:0]             sleep_sync;
		logic [SUBSECOND_W-1:0] subsecond;
		rca_time_t              live;
		rca_time_t              shadow;
		logic [5:0][7:0]        alarm;
		logic [7:0]             ctrl;
		logic                   power_up;
		logic                   alarm_flag;
		logic [3:0]             events;
		logic                   run;
		logic [4:0]             intc;
		logic                   per_pend;
		logic [PULSE_W-1:0]     pulse_cnt;
		logic                   tick_d;
		logic [7:0]             rdata;
		logic                   alarm_irq_n;
		logic                   timer_irq_n;
	} rca_state_t;
endpackage : rca_pkg

// ### sim/rca_host_model.sv
// Host-side model that drives the register strobe port of the calendar block.
`timescale 1ns/10ps
`default_nettype none
module rca_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic [7:0] i_reg_rdata,
	output logic      [7:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_wr,
	output logic            o_reg_rd
);
	initial begin
		o_reg_addr  = 8'h00;
		o_reg_wdata = 8'h00;
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
	end

	// Write data is inverted once released, so a stale value never looks valid.
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge i_clk_sys);
		o_reg_addr  = addr;
		o_reg_wdata = data;
		o_reg_wr    = 1'b1;
		@(negedge i_clk_sys);
		o_reg_wr    = 1'b0;
		o_reg_wdata = ~data;
	endtask : wr_reg

	task automatic rd_once(input logic [7:0] addr, output logic [7:0] data);
		@(negedge i_clk_sys);
		o_reg_addr = addr;
		o_reg_rd   = 1'b1;
		@(negedge i_clk_sys);
		o_reg_rd   = 1'b0;
		@(negedge i_clk_sys);
		data = i_reg_rdata;
	endtask : rd_once

	// Control and status get a throwaway read first; for status it clears the elapsed flags.
	task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
		logic [7:0] scratch;
		if (addr == rca_pkg::OFF_CTRL || addr == rca_pkg::OFF_STATUS) rd_once(addr, scratch);
		rd_once(addr, data);
	endtask : rd_reg
endmodule : rca_host_model
`default_nettype wire

// ### sim/rca_calendar_regs_tb_top.sv
// Self-checking bench for the calendar and alarm register block.
`timescale 1ns/10ps
`default_nettype none
module rca_calendar_regs_tb_top;
	localparam logic [7:0] RST_OFF [9] = '{rca_pkg::OFF_MONTH, rca_pkg::OFF_YEAR, rca_pkg::OFF_WEEKDAY,
		rca_pkg::OFF_ALM_DAY, rca_pkg::OFF_ALM_MONTH, rca_pkg::OFF_ALM_YEAR, rca_pkg::OFF_CTRL,
		rca_pkg::OFF_STATUS, rca_pkg::OFF_INTC};
	localparam logic [7:0] RST_VAL [9] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00};
	localparam logic [7:0] FLD_OFF [9] = '{rca_pkg::OFF_WEEKDAY, rca_pkg::OFF_ALM_SECOND, rca_pkg::OFF_ALM_MINUTE,
		rca_pkg::OFF_ALM_HOUR, rca_pkg::OFF_ALM_DAY, rca_pkg::OFF_ALM_MONTH, rca_pkg::OFF_ALM_YEAR,
		rca_pkg::OFF_YEAR, 8'h07};
	localparam logic [7:0] FLD_WR  [9] = '{8'hFD, 8'hD9, 8'hC5, 8'hE3, 8'hF1, 8'hF2, 8'h98, 8'h99, 8'h5A};
	localparam logic [7:0] FLD_RD  [9] = '{8'h05, 8'h59, 8'h45, 8'h23, 8'h31, 8'h12, 8'h98, 8'h99, 8'h00};
	localparam logic [7:0] TIME_V  [6] = '{8'h58, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99};
	localparam logic [7:0] WRAP_V  [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] ALM_V   [6] = '{8'h02, 8'h11, 8'h00, 8'h01, 8'h01, 8'h00};
	localparam logic [7:0] PER_IC  [5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h01};
	localparam logic       PER_EXP [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

	logic        clk;
	logic        rst_n;
	logic        clk32k;
	logic        sleep;
	logic [15:0] comp;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        alarm_n;
	logic        timer_n;
	logic [7:0]  v;
	int          lows;
	int          failures;
	int          n_checks;

	initial clk = 1'b0;
	always #5 clk = ~clk;
	// The oscillator starts off a sys edge so no oscillator edge ever lands on a sys edge.
	initial begin
		clk32k = 1'b0;
		#3;
		forever #62.5 clk32k = ~clk32k;
	end

	rca_calendar_regs #(.TICKS_PER_SECOND(4)) DUT (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_32k(clk32k), .i_sleep(sleep), .i_comp_value(comp),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.o_alarm_irq_n(alarm_n), .o_timer_irq_n(timer_n));

	rca_host_model HOST (
		.i_clk_sys(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_wr(wr),
		.o_reg_rd(rd));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] d;
		HOST.rd_reg(a, d);
		check(16'(d & m), 16'(e));
	endtask : rdchk

	task automatic count_low(input int span, output int n);
		n = 0;
		repeat (span) begin
			if (timer_n === 1'b0) n++;
			@(negedge clk);
		end
	endtask : count_low

	task automatic stop_test();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		#1000000;
		failures++;
		stop_test();
	end

	initial begin
		failures = 0;
		n_checks = 0;
		rst_n = 1'b0;
		sleep = 1'b0;
		comp  = 16'h0000;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		foreach (RST_OFF[i]) rdchk(RST_OFF[i], RST_VAL[i], 8'hFF);
		$display("test reset_values done");
		foreach (FLD_OFF[i]) HOST.wr_reg(FLD_OFF[i], FLD_WR[i]);
		foreach (FLD_OFF[i]) rdchk(FLD_OFF[i], FLD_RD[i], 8'hFF);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h08);
		HOST.wr_reg(rca_pkg::OFF_ALM_HOUR, 8'h91);
		rdchk(rca_pkg::OFF_ALM_HOUR, 8'h91, 8'hFF);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		HOST.wr_reg(rca_pkg::OFF_STATUS, 8'h80);
		rdchk(rca_pkg::OFF_STATUS, 8'h00, 8'hFF);
		$display("test field_layout done");
		for (int i = 0; i < 6; i++) HOST.wr_reg(8'(i), TIME_V[i]);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h01);
		repeat (60) @(negedge clk);
		HOST.rd_once(rca_pkg::OFF_STATUS, v);
		check(16'(v & 8'h03), 16'h0002);
		repeat (60) @(negedge clk);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		repeat (40) @(negedge clk);
		// Any status read clears the elapsed flags, so this one read must be the first.
		HOST.rd_once(rca_pkg::OFF_STATUS, v);
		check(16'(v), 16'h003C);
		for (int i = 0; i < 6; i++) rdchk(8'(i), WRAP_V[i], 8'hFF);
		$display("test rollover done");
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h40);
		HOST.wr_reg(rca_pkg::OFF_SECOND, 8'h30);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'hC0);
		rdchk(rca_pkg::OFF_SECOND, 8'h00, 8'hFF);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h80);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'hC0);
		rdchk(rca_pkg::OFF_SECOND, 8'h30, 8'hFF);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		rdchk(rca_pkg::OFF_SECOND, 8'h30, 8'hFF);
		$display("test shadow done");
		HOST.wr_reg(rca_pkg::OFF_SECOND, 8'h45);
		HOST.wr_reg(rca_pkg::OFF_MINUTE, 8'h10);
		@(posedge clk32k);
		repeat (5) @(negedge clk);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h02);
		HOST.rd_once(rca_pkg::OFF_CTRL, v);
		check(16'(v), 16'h0002);
		repeat (30) @(negedge clk);
		rdchk(rca_pkg::OFF_CTRL, 8'h00, 8'hFF);
		rdchk(rca_pkg::OFF_SECOND, 8'h00, 8'hFF);
		rdchk(rca_pkg::OFF_MINUTE, 8'h11, 8'hFF);
		$display("test rounding done");
		for (int i = 0; i < 6; i++) HOST.wr_reg(rca_pkg::OFF_ALM_SECOND + 8'(i), ALM_V[i]);
		HOST.wr_reg(rca_pkg::OFF_INTC, 8'h08);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h01);
		for (int i = 0; i < 300 && alarm_n !== 1'b0; i++) @(negedge clk);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		check(16'(alarm_n), 16'h0000);
		rdchk(rca_pkg::OFF_STATUS, 8'h40, 8'h40);
		check(16'(alarm_n), 16'h0000);
		HOST.wr_reg(rca_pkg::OFF_STATUS, 8'h40);
		repeat (3) @(negedge clk);
		check(16'(alarm_n), 16'h0001);
		rdchk(rca_pkg::OFF_STATUS, 8'h00, 8'h40);
		$display("test alarm done");
		// Each period starts at 00:10:58, so only second and minute boundaries are crossed.
		foreach (PER_IC[i]) begin
			HOST.wr_reg(rca_pkg::OFF_SECOND, 8'h58);
			HOST.wr_reg(rca_pkg::OFF_MINUTE, 8'h10);
			HOST.wr_reg(rca_pkg::OFF_INTC, PER_IC[i]);
			HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h01);
			count_low(200, lows);
			check(16'(lows != 0), 16'(PER_EXP[i]));
			HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
			HOST.wr_reg(rca_pkg::OFF_INTC, 8'h00);
			repeat (3100) @(negedge clk);
		end
		$display("test periodic_modes done");
		// With the preload at the last tick, the first counted oscillator edge ends the second early.
		comp = 16'h0003;
		HOST.wr_reg(rca_pkg::OFF_SECOND, 8'h10);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h20);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h01);
		repeat (32) @(negedge clk);
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		rdchk(rca_pkg::OFF_SECOND, 8'h11, 8'hFF);
		$display("test subsecond_load done");
		HOST.wr_reg(rca_pkg::OFF_SECOND, 8'h58);
		HOST.wr_reg(rca_pkg::OFF_INTC, 8'h15);
		sleep = 1'b1;
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h01);
		count_low(300, lows);
		check(16'(lows), 16'h0000);
		sleep = 1'b0;
		for (int i = 0; i < 20 && timer_n !== 1'b0; i++) @(negedge clk);
		count_low(1600, lows);
		check(16'(lows), 16'(rca_pkg::TIMER_PULSE_CYC));
		HOST.wr_reg(rca_pkg::OFF_CTRL, 8'h00);
		$display("test sleep_hold done");
		stop_test();
	end
endmodule : rca_calendar_regs_tb_top
`default_nettype wire
